// [dsr_pkg.sv]
// Shared constants and types for the dual SAR converter control and serial readout
package dsr_pkg;
  localparam int          RES_BITS     = 16;
  localparam int          CH_NUM       = 2;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          CNT_W        = 5;
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          CYC_MIN_NS   = 500;
  localparam int          CYC_MIN_CYC  = (CYC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] LAST_STEP = 5'h0F;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
  localparam logic [15:0] TRIAL_TOP    = 16'h8000;
  localparam logic [15:0] CODE_ZERO    = 16'h0000;
  localparam logic [15:0] CODE_POS_FS  = 16'h7FFF;
  localparam logic [15:0] CODE_NEG_FS  = 16'h8000;
  localparam int          SIGN_POS     = 15;

  typedef enum logic [1:0] {
    DSR_IO_SINGLE,
    DSR_IO_DIFF,
    DSR_IO_DIFF_LOWPWR
  } dsr_io_mode_t;

  // One leg pair of a serial output with its drive enables
  typedef struct packed {
    logic p;
    logic n;
    logic oe_p;
    logic oe_n;
  } dsr_pair_t;

  // Result of both channels from one conversion
  typedef struct packed {
    logic [RES_BITS-1:0] ch1;
    logic [RES_BITS-1:0] ch2;
  } dsr_result_t;
endpackage : dsr_pkg

// [dsr_adc_readout.sv]
// Conversion control, result buffer and serial readout of the dual SAR converter
`timescale 1ns/1ps

module dsr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data  = mem[rd_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d      = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d     = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; occupancy decides what is valid
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule : dsr_fifo

module dsr_adc_readout
  import dsr_pkg::*;
#(
  parameter int RES   = dsr_pkg::RES_BITS,
  parameter int DEPTH = dsr_pkg::FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              conversion_start_n,
  input  wire logic              shift_clk,
  input  wire logic              io_sel_high,
  input  wire logic              io_sel_float,
  input  wire logic              clk_n_tied_high,
  input  wire logic              ch1_cmp,
  input  wire logic              ch2_cmp,
  output logic                   sample_hold,
  output logic [RES-1:0]         ch1_capacitive_dac,
  output logic [RES-1:0]         ch2_capacitive_dac,
  output logic                   io_low_power,
  output dsr_pkg::dsr_io_mode_t  io_mode,
  output dsr_pkg::dsr_pair_t     ch1_serial_out,
  output dsr_pkg::dsr_pair_t     ch2_serial_out,
  output dsr_pkg::dsr_pair_t     returned_data_clock,
  output logic                   conv_busy
);
  import dsr_pkg::*;

  typedef enum logic [1:0] {
    DSR_ACQUIRE,
    DSR_CONVERT,
    DSR_STORE
  } dsr_state_t;

  // Conversion state
  dsr_state_t       st_q;
  dsr_state_t       st_d;
  logic [CNT_W-1:0] step_q;
  logic [CNT_W-1:0] step_d;
  logic [RES-1:0]   trial_q;
  logic [RES-1:0]   trial_d;
  logic [RES-1:0]   code_q [CH_NUM];
  logic [RES-1:0]   code_d [CH_NUM];
  logic             cnv_prev_q;
  logic             cnv_fall;
  logic             cnv_rise;
  logic [CH_NUM-1:0] cmp;
  dsr_result_t      res_word;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  dsr_result_t      fifo_out;

  // Readout state
  logic [RES-1:0]   sh1_q;
  logic [RES-1:0]   sh1_d;
  logic [RES-1:0]   sh2_q;
  logic [RES-1:0]   sh2_d;
  logic             drive_q;
  logic             drive_d;
  logic             sck_prev_q;
  logic             sck_fall;
  logic             rclk_q;
  logic             rclk_d;
  dsr_io_mode_t     mode_d;
  dsr_pair_t        so1_d;
  dsr_pair_t        so2_d;
  dsr_pair_t        rck_d;
  dsr_pair_t        so1_q;
  dsr_pair_t        so2_q;
  dsr_pair_t        rck_q;

  // Start input sampled the same way whatever the signalling mode
  assign cnv_fall = cnv_prev_q && !conversion_start_n;
  assign cnv_rise = !cnv_prev_q && conversion_start_n;
  assign sck_fall = sck_prev_q && !shift_clk;
  assign cmp      = {ch2_cmp, ch1_cmp};

  always_comb begin
    st_d          = st_q;
    step_d        = step_q;
    trial_d       = trial_q;
    code_d        = code_q;
    fifo_in_valid = 1'b0;
    unique case (st_q)
      DSR_ACQUIRE: begin
        if (cnv_fall) begin
          st_d    = DSR_CONVERT;
          step_d  = CNT_ZERO;
          trial_d = TRIAL_TOP;
          for (int c = 0; c < CH_NUM; c++) begin
            code_d[c] = TRIAL_TOP;
          end
        end
      end
      DSR_CONVERT: begin
        // Comparator high means input at or above the trial level: keep the bit
        for (int c = 0; c < CH_NUM; c++) begin
          code_d[c] = cmp[c] ? code_q[c] : (code_q[c] & ~trial_q);
          code_d[c] = code_d[c] | (trial_q >> 1);
        end
        trial_d = trial_q >> 1;
        step_d  = CNT_W'(step_q + 1'b1);
        if (step_q == LAST_STEP) begin
          st_d = DSR_STORE;
        end
      end
      DSR_STORE: begin
        // Waits here while the buffer is full, stalling the next conversion
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          st_d = DSR_ACQUIRE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q       <= DSR_ACQUIRE;
      step_q     <= CNT_ZERO;
      trial_q    <= CODE_ZERO;
      code_q     <= '{default: CODE_ZERO};
      cnv_prev_q <= 1'b1;
    end else begin
      st_q       <= st_d;
      step_q     <= step_d;
      trial_q    <= trial_d;
      code_q     <= code_d;
      cnv_prev_q <= conversion_start_n;
    end
  end

  // Offset-binary SAR code to two's complement by inverting the sign bit
  assign res_word.ch1 = {~code_q[0][SIGN_POS], code_q[0][SIGN_POS-1:0]};
  assign res_word.ch2 = {~code_q[1][SIGN_POS], code_q[1][SIGN_POS-1:0]};

  assign sample_hold        = (st_q != DSR_ACQUIRE);
  assign conv_busy          = sample_hold;
  assign ch1_capacitive_dac = code_q[0];
  assign ch2_capacitive_dac = code_q[1];

  dsr_fifo #(
    .WIDTH ($bits(dsr_result_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (res_word),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out)
  );

  always_comb begin
    // Floating select wins: strap reads neither low nor high
    if (io_sel_float) begin
      mode_d = DSR_IO_DIFF_LOWPWR;
    end else if (io_sel_high) begin
      mode_d = DSR_IO_DIFF;
    end else begin
      mode_d = DSR_IO_SINGLE;
    end
    sh1_d   = sh1_q;
    sh2_d   = sh2_q;
    drive_d = drive_q;
    rclk_d  = shift_clk;
    // Release first, so a word landing in the same cycle still gets driven
    if (cnv_rise) begin
      drive_d = 1'b0;
    end
    // Buffer pops each word the cycle after it lands, so no older result waits
    if (fifo_out_valid) begin
      sh1_d   = fifo_out.ch1;
      sh2_d   = fifo_out.ch2;
      drive_d = 1'b1;
    end else if (sck_fall) begin
      sh1_d = {sh1_q[RES-2:0], 1'b0};
      sh2_d = {sh2_q[RES-2:0], 1'b0};
    end
    so1_d.p    = sh1_q[RES-1];
    so1_d.n    = ~sh1_q[RES-1];
    so1_d.oe_p = drive_q;
    so1_d.oe_n = drive_q && (mode_d != DSR_IO_SINGLE);
    so2_d.p    = sh2_q[RES-1];
    so2_d.n    = ~sh2_q[RES-1];
    so2_d.oe_p = drive_q;
    so2_d.oe_n = drive_q && (mode_d != DSR_IO_SINGLE);
    // Clock copy takes the same register stage as the data for matched skew
    rck_d.p    = rclk_q;
    rck_d.n    = ~rclk_q;
    rck_d.oe_p = !((mode_d == DSR_IO_SINGLE) && clk_n_tied_high);
    rck_d.oe_n = (mode_d != DSR_IO_SINGLE);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sh1_q      <= CODE_ZERO;
      sh2_q      <= CODE_ZERO;
      drive_q    <= 1'b0;
      sck_prev_q <= 1'b0;
      rclk_q     <= 1'b0;
      io_mode    <= DSR_IO_SINGLE;
      so1_q      <= '0;
      so2_q      <= '0;
      rck_q      <= '0;
    end else begin
      sh1_q      <= sh1_d;
      sh2_q      <= sh2_d;
      drive_q    <= drive_d;
      sck_prev_q <= shift_clk;
      rclk_q     <= rclk_d;
      io_mode    <= mode_d;
      so1_q      <= so1_d;
      so2_q      <= so2_d;
      rck_q      <= rck_d;
    end
  end

  assign io_low_power        = (io_mode == DSR_IO_DIFF_LOWPWR);
  assign ch1_serial_out      = so1_q;
  assign ch2_serial_out      = so2_q;
  assign returned_data_clock = rck_q;
endmodule : dsr_adc_readout

// [dsr_readout_assertions.sv]
// Concurrent checks on the ports of the dual SAR readout block
`timescale 1ns/1ps

module dsr_readout_assertions
  import dsr_pkg::*;
#(
  parameter int RES = dsr_pkg::RES_BITS
) (
  input wire logic               clock,
  input wire logic               rst_n,
  input wire logic               conversion_start_n,
  input wire logic               shift_clk,
  input wire logic               clk_n_tied_high,
  input wire logic               sample_hold,
  input wire logic [RES-1:0]     ch1_capacitive_dac,
  input wire dsr_pkg::dsr_io_mode_t io_mode,
  input wire dsr_pkg::dsr_pair_t ch1_serial_out,
  input wire dsr_pkg::dsr_pair_t ch2_serial_out,
  input wire dsr_pkg::dsr_pair_t returned_data_clock
);
  import dsr_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_hold_on_start : assert property (
    $fell(conversion_start_n) && !sample_hold |=> sample_hold && ch1_capacitive_dac == TRIAL_TOP)
    else $error("hold or first trial missing after start");
  chk_conv_phase : assert property (
    $rose(sample_hold) |-> sample_hold[*8])
    else $error("conversion phase cut short");
  chk_result_load : assert property (
    $fell(sample_hold) |-> ##[1:3] ch1_serial_out.oe_p && ch2_serial_out.oe_p)
    else $error("result not presented after conversion");
  chk_data_release : assert property (
    $rose(conversion_start_n) |-> ##3 !ch1_serial_out.oe_p && !ch2_serial_out.oe_p)
    else $error("serial data still driven after start rose");
  chk_single_legs : assert property (
    (io_mode == DSR_IO_SINGLE) [*3] |-> !ch1_serial_out.oe_n && !ch2_serial_out.oe_n)
    else $error("negative data leg driven in single-ended mode");
  chk_diff_inverse : assert property (
    ch1_serial_out.oe_p && ch1_serial_out.oe_n |-> ch1_serial_out.n == !ch1_serial_out.p)
    else $error("differential legs not complementary");
  chk_clock_follow : assert property (
    returned_data_clock.p == $past(shift_clk, 2))
    else $error("returned clock does not follow shift clock");
  chk_clock_gate : assert property (
    (io_mode == DSR_IO_SINGLE && clk_n_tied_high) [*3] |-> !returned_data_clock.oe_p)
    else $error("returned clock not disabled");
  chk_clock_diff : assert property (
    (io_mode != DSR_IO_SINGLE) [*3] |-> returned_data_clock.oe_n)
    else $error("returned clock negative leg idle in differential mode");
endmodule : dsr_readout_assertions

bind dsr_adc_readout dsr_readout_assertions #(.RES(RES)) u_chk (.clock, .rst_n, .conversion_start_n, .shift_clk,
  .clk_n_tied_high, .sample_hold, .ch1_capacitive_dac, .io_mode, .ch1_serial_out, .ch2_serial_out,
  .returned_data_clock);

// [dsr_host_model.sv]
// Host that starts a conversion and shifts both results out
`timescale 1ns/1ps

module dsr_host_model
  import dsr_pkg::*;
(
  input wire logic               clock,
  input wire logic               go,
  input wire dsr_pkg::dsr_pair_t ch1_serial_out,
  input wire dsr_pkg::dsr_pair_t ch2_serial_out,
  output logic                   conversion_start_n,
  output logic                   shift_clk,
  output dsr_pkg::dsr_result_t   words,
  output logic                   done
);
  import dsr_pkg::*;
  // One process owns every output; shift clock stands low between frames
  initial begin
    conversion_start_n = 1'b1;
    shift_clk = 1'b0;
    words = '0;
    done = 1'b0;
    forever begin
      @(posedge clock iff go === 1'b1);
      #1 done = 1'b0;
      conversion_start_n = 1'b0;
      // Wait past conversion; also keeps starts far apart
      repeat (22) @(posedge clock);
      for (int i = 15; i >= 0; i--) begin
        // An undriven leg reads as the inverse, so a late drive shows up
        #1 words.ch1[i] = ch1_serial_out.oe_p ? ch1_serial_out.p : ~ch1_serial_out.p;
        words.ch2[i] = ch2_serial_out.oe_p ? ch2_serial_out.p : ~ch2_serial_out.p;
        shift_clk = 1'b1;
        repeat (3) @(posedge clock);
        #1 shift_clk = 1'b0;
        repeat (4) @(posedge clock);
      end
      #1 conversion_start_n = 1'b1;
      done = 1'b1;
    end
  end
endmodule : dsr_host_model

// [dual_sar_adc_serial_readout_tb_top.sv]
// Self-checking bench for the dual SAR readout block
`timescale 1ns/1ps

`define CHECK(name, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", name, exp, got); end end

module dual_sar_adc_serial_readout_tb_top;
  import dsr_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, go = 1'b0;
  logic io_sel_high = 1'b0, io_sel_float = 1'b0, clk_n_tied_high = 1'b0;
  logic [15:0] in1 = 16'h0000, in2 = 16'h0000, ch1_capacitive_dac, ch2_capacitive_dac;
  logic conversion_start_n, shift_clk, ch1_cmp, ch2_cmp, sample_hold, io_low_power, conv_busy, done;
  dsr_io_mode_t io_mode;
  dsr_pair_t ch1_serial_out, ch2_serial_out, returned_data_clock;
  dsr_result_t words;
  int mismatches = 0, checked = 0;

  // Ideal comparators: offset-binary input against the trial level
  assign ch1_cmp = (in1 >= ch1_capacitive_dac);
  assign ch2_cmp = (in2 >= ch2_capacitive_dac);

  dsr_adc_readout #(.RES(RES_BITS), .DEPTH(FIFO_DEPTH)) dut (.clock, .rst_n, .conversion_start_n, .shift_clk,
    .io_sel_high, .io_sel_float, .clk_n_tied_high, .ch1_cmp, .ch2_cmp, .sample_hold, .ch1_capacitive_dac,
    .ch2_capacitive_dac, .io_low_power, .io_mode, .ch1_serial_out, .ch2_serial_out, .returned_data_clock,
    .conv_busy);
  dsr_host_model u_host (.clock, .go, .ch1_serial_out, .ch2_serial_out, .conversion_start_n, .shift_clk,
    .words, .done);

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic t_modes();
    dsr_io_mode_t exp;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      #1 {io_sel_high, io_sel_float} = i[1:0];
      exp = io_sel_float ? DSR_IO_DIFF_LOWPWR : (io_sel_high ? DSR_IO_DIFF : DSR_IO_SINGLE);
      repeat (3) @(posedge clock);
      #1 `CHECK("io mode", exp, io_mode)
      `CHECK("low power", io_sel_float, io_low_power)
    end
  endtask : t_modes

  task automatic t_conv(input logic [15:0] c1, input logic [15:0] c2, input logic hi, input logic fl,
                        input logic tied);
    @(posedge clock);
    #1 {io_sel_high, io_sel_float, clk_n_tied_high} = {hi, fl, tied};
    in1 = c1 ^ 16'h8000;
    in2 = c2 ^ 16'h8000;
    repeat (3) @(posedge clock);
    #1 go = 1'b1;
    @(posedge clock);
    #1 go = 1'b0;
    repeat (5) @(posedge clock);
    #1 `CHECK("holding", 1'b1, sample_hold)
    `CHECK("busy", 1'b1, conv_busy)
    repeat (25) @(posedge clock);
    #1 `CHECK("negative data leg", hi | fl, ch1_serial_out.oe_n)
    `CHECK("ch2 negative leg", hi | fl, ch2_serial_out.oe_n)
    `CHECK("clock negative leg", hi | fl, returned_data_clock.oe_n)
    `CHECK("clock enable", !(!hi && !fl && tied), returned_data_clock.oe_p)
    for (int n = 0; n < 400 && done !== 1'b1; n++) @(posedge clock);
    `CHECK("frame done", 1'b1, done)
    `CHECK("ch1 word", c1, words.ch1)
    `CHECK("ch2 word", c2, words.ch2)
    repeat (4) @(posedge clock);
    #1 `CHECK("data released", 1'b0, ch1_serial_out.oe_p | ch2_serial_out.oe_p)
    `CHECK("acquiring", 1'b0, sample_hold)
  endtask : t_conv

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clock);
    t_modes();
    t_conv(16'h7FFF, 16'h8000, 1'b0, 1'b0, 1'b0);
    t_conv(16'h0000, 16'hA5C3, 1'b0, 1'b0, 1'b1);
    t_conv(16'h8000, 16'h7FFF, 1'b1, 1'b0, 1'b1);
    t_conv(16'h1234, 16'hFFFF, 1'b0, 1'b1, 1'b0);
    report_and_stop();
  end
endmodule : dual_sar_adc_serial_readout_tb_top
